// file: verilog/ctc_pkg.sv
// package: constants and carrier types for the cassette tape byte codec
package ctc_pkg;

    // ------------------------------------------------------------
    // clock and tone timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned ZERO_TONE_HZ  = 2000;
    localparam int unsigned ONE_TONE_HZ   = 800;
    localparam int unsigned LEADER_MS     = 4000;
    localparam int unsigned THRESH_US     = 875;
    localparam int unsigned GAP_US        = 2500;
    localparam int unsigned ZERO_HALF_CYC = CLK_HZ / ZERO_TONE_HZ / 2;
    localparam int unsigned ONE_HALF_CYC  = CLK_HZ / ONE_TONE_HZ / 2;
    localparam int unsigned THRESH_CYC    = THRESH_US * (CLK_HZ / 1_000_000);
    localparam int unsigned GAP_CYC       = GAP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned LEADER_CYC    = LEADER_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    localparam int   CNT_W      = 32;
    localparam int   DATA_BITS  = 8;
    localparam int   FRAME_BITS = 10;
    localparam int   RX_BITS    = 9;
    localparam int   COUNT_W    = 16;
    localparam logic START_BIT  = 1'b1;

    typedef struct packed {
        logic [DATA_BITS-1:0] data;
        logic                 parity_ok;
    } ctc_rx_word_s;

    typedef struct packed {
        logic valid;
        logic one;
    } ctc_bit_s;

endpackage : ctc_pkg

// file: verilog/ctc_pair_buffer.sv
// module: two-entry buffer with valid and full on the filling side, valid and ready on the draining side
module ctc_pair_buffer #(
    parameter int W = 9
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    // filling side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              full,
    // draining side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);

    if (W < 1) begin : g_bad_w
        $error("buffer width must be positive");
    end

    logic         head_vld_reg;
    logic         tail_vld_reg;
    logic [W-1:0] head_reg;
    logic [W-1:0] tail_reg;

    wire pop  = head_vld_reg & out_ready;
    wire push = in_valid & ~tail_vld_reg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            head_vld_reg <= 1'b0;
            tail_vld_reg <= 1'b0;
            head_reg     <= '0;
            tail_reg     <= '0;
        end else if (pop && tail_vld_reg) begin
            head_reg     <= tail_reg;
            tail_vld_reg <= 1'b0;
        end else if (pop || !head_vld_reg) begin
            head_reg     <= in_data;
            head_vld_reg <= push;
        end else if (push) begin
            tail_reg     <= in_data;
            tail_vld_reg <= 1'b1;
        end
    end

    assign full      = tail_vld_reg;
    assign out_valid = head_vld_reg;
    assign out_data  = head_reg;

    a_buf_hold : assert property (@(posedge sys_clk) disable iff (!resetn)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
        else $error("buffer head changed while stalled");

endmodule : ctc_pair_buffer

// file: verilog/ctc_cycle_meter.sv
// module: measures tape input cycles and classifies each as a zero or one
module ctc_cycle_meter #(
    parameter int unsigned THRESH = ctc_pkg::THRESH_CYC,
    parameter int unsigned GAP    = ctc_pkg::GAP_CYC
) (
    // clock and reset
    input  wire logic      sys_clk,
    input  wire logic      resetn,
    // conditioned tape signal, asynchronous
    input  wire logic      tape_in,
    // classified cycle
    output ctc_pkg::ctc_bit_s bit_out
);

    if (THRESH < 2 || GAP <= THRESH) begin : g_bad_meter
        $error("gap must lie above the threshold");
    end

    localparam logic [ctc_pkg::CNT_W-1:0] TH = ctc_pkg::CNT_W'(THRESH);
    localparam logic [ctc_pkg::CNT_W-1:0] GP = ctc_pkg::CNT_W'(GAP);

    logic                       s1_reg;
    logic                       s2_reg;
    logic                       s3_reg;
    logic                       seen_reg;
    logic [ctc_pkg::CNT_W-1:0]  period_reg;
    ctc_pkg::ctc_bit_s          bit_reg;

    wire rise   = s2_reg & ~s3_reg;
    wire in_gap = period_reg >= GP;

    // s1 is read by s2 only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= tape_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a rise after silence only restarts timing; no bit is made from it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            period_reg <= '0;
            seen_reg   <= 1'b0;
            bit_reg    <= '0;
        end else begin
            bit_reg.valid <= rise & seen_reg & ~in_gap;
            bit_reg.one   <= period_reg >= TH;
            if (rise) begin
                period_reg <= ctc_pkg::CNT_W'(1);
                seen_reg   <= 1'b1;
            end else if (!in_gap) begin
                period_reg <= period_reg + ctc_pkg::CNT_W'(1);
            end
        end
    end

    assign bit_out = bit_reg;

    a_meter_class : assert property (@(posedge sys_clk) disable iff (!resetn)
        (rise && seen_reg && !in_gap) |=> (bit_reg.valid && (bit_reg.one == ($past(period_reg) >= TH))))
        else $error("cycle misclassified against threshold");

endmodule : ctc_cycle_meter

// file: verilog/ctc_codec.sv
// module: cassette tape byte codec, tone encoder and tone decoder
module ctc_codec #(
    parameter int unsigned ZERO_HALF = ctc_pkg::ZERO_HALF_CYC,
    parameter int unsigned ONE_HALF  = ctc_pkg::ONE_HALF_CYC,
    parameter int unsigned THRESH    = ctc_pkg::THRESH_CYC,
    parameter int unsigned GAP       = ctc_pkg::GAP_CYC,
    parameter int unsigned LEADER    = ctc_pkg::LEADER_CYC
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    // transmit command
    input  wire logic                          tx_start,
    input  wire logic [ctc_pkg::COUNT_W-1:0]   tx_count,
    output logic                               tx_busy,
    // transmit byte stream
    input  wire logic                          tx_byte_valid,
    input  wire logic [ctc_pkg::DATA_BITS-1:0] tx_byte,
    output logic                               tx_byte_ready,
    // tape pins
    output logic                               tape_out_flag,
    input  wire logic                          second_external_flag_input,
    // receive byte stream
    output logic                               rx_valid,
    output ctc_pkg::ctc_rx_word_s              rx_word,
    input  wire logic                          rx_ready,
    output logic                               rx_overrun
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (ZERO_HALF < 1 || ONE_HALF <= ZERO_HALF) begin : g_bad_half
        $error("tone half periods out of order");
    end
    if (THRESH <= 2 * ZERO_HALF || THRESH >= 2 * ONE_HALF || GAP <= 2 * ONE_HALF) begin : g_bad_thresh
        $error("threshold must lie between the two periods");
    end

    localparam logic [ctc_pkg::CNT_W-1:0] ZH  = ctc_pkg::CNT_W'(ZERO_HALF);
    localparam logic [ctc_pkg::CNT_W-1:0] OH  = ctc_pkg::CNT_W'(ONE_HALF);
    localparam logic [ctc_pkg::CNT_W-1:0] LDR = ctc_pkg::CNT_W'(LEADER);
    localparam logic [3:0]                FB  = 4'(ctc_pkg::FRAME_BITS);
    localparam logic [3:0]                RB  = 4'(ctc_pkg::RX_BITS);

    typedef enum logic [1:0] {TX_IDLE, TX_LEADER, TX_FRAME} ctc_tx_state_e;
    typedef enum logic {RX_HUNT, RX_DATA} ctc_rx_state_e;

    // ------------------------------------------------------------
    // transmit byte holding register
    // ------------------------------------------------------------
    logic                          hold_full_reg;
    logic [ctc_pkg::DATA_BITS-1:0] hold_reg;
    logic                          ready_reg;
    logic                          load;

    wire accept         = tx_byte_valid & ready_reg;
    wire hold_full_next = accept | (hold_full_reg & ~load);

    // one byte is prefetched so the next frame can start with no gap
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hold_full_reg <= 1'b0;
            hold_reg      <= '0;
            ready_reg     <= 1'b0;
        end else begin
            hold_full_reg <= hold_full_next;
            ready_reg     <= ~hold_full_next;
            if (accept) begin
                hold_reg <= tx_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // tone encoder
    // ------------------------------------------------------------
    ctc_tx_state_e                 tx_state_reg;
    ctc_tx_state_e                 tx_state_next;
    logic [ctc_pkg::CNT_W-1:0]     half_cnt_reg;
    logic [ctc_pkg::CNT_W-1:0]     leader_left_reg;
    logic [ctc_pkg::COUNT_W-1:0]   bytes_left_reg;
    logic [ctc_pkg::FRAME_BITS-1:0] shift_reg;
    logic [3:0]                    bits_left_reg;
    logic                          phase_reg;
    logic                          tape_reg;
    logic                          busy_reg;

    wire [ctc_pkg::CNT_W-1:0] half_len = shift_reg[0] ? OH : ZH;
    wire half_done  = (tx_state_reg != TX_IDLE) && (half_cnt_reg == half_len - ctc_pkg::CNT_W'(1));
    wire bit_end    = half_done & phase_reg;
    wire frame_end  = bits_left_reg <= 4'h1;
    wire leader_ok  = leader_left_reg == '0;
    wire want_byte  = bit_end && (bytes_left_reg != '0) &&
                      ((tx_state_reg == TX_LEADER && leader_ok) || (tx_state_reg == TX_FRAME && frame_end));
    wire last_done  = bit_end && tx_state_reg == TX_FRAME && frame_end && bytes_left_reg == '0;
    wire start_ok   = tx_start && tx_state_reg == TX_IDLE && tx_count != '0;
    wire par_bit    = ~^hold_reg;
    wire [ctc_pkg::FRAME_BITS-1:0] frame_word = {par_bit, hold_reg, ctc_pkg::START_BIT};

    assign load = want_byte & hold_full_reg;

    always_comb begin
        tx_state_next = tx_state_reg;
        case (tx_state_reg)
            TX_IDLE:   if (start_ok) tx_state_next = TX_LEADER;
            TX_LEADER: if (load) tx_state_next = TX_FRAME;
            TX_FRAME:  if (last_done) tx_state_next = TX_IDLE;
            default:   tx_state_next = TX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx_state_reg <= TX_IDLE;
            busy_reg     <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            busy_reg     <= tx_state_next != TX_IDLE;
        end
    end

    // leader runs on whole zero bits; it ends at the first bit edge past its time at which a byte is held
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            leader_left_reg <= '0;
            bytes_left_reg  <= '0;
        end else if (start_ok) begin
            leader_left_reg <= LDR;
            bytes_left_reg  <= tx_count;
        end else begin
            if (tx_state_reg == TX_LEADER && !leader_ok) begin
                leader_left_reg <= leader_left_reg - ctc_pkg::CNT_W'(1);
            end
            if (load) begin
                bytes_left_reg <= bytes_left_reg - ctc_pkg::COUNT_W'(1);
            end
        end
    end

    // a late byte stretches the line with zero bits, which the receiver skips
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shift_reg     <= '0;
            bits_left_reg <= '0;
        end else if (start_ok) begin
            shift_reg     <= '0;
            bits_left_reg <= '0;
        end else if (load) begin
            shift_reg     <= frame_word;
            bits_left_reg <= FB;
        end else if (bit_end) begin
            shift_reg     <= shift_reg >> 1;
            bits_left_reg <= (bits_left_reg == 4'h0) ? 4'h0 : bits_left_reg - 4'h1;
        end
    end

    // each bit is one full cycle: high half, then low half
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            half_cnt_reg <= '0;
            phase_reg    <= 1'b0;
            tape_reg     <= 1'b0;
        end else if (start_ok) begin
            half_cnt_reg <= '0;
            phase_reg    <= 1'b0;
            tape_reg     <= 1'b1;
        end else if (half_done) begin
            half_cnt_reg <= '0;
            phase_reg    <= ~phase_reg;
            tape_reg     <= last_done ? 1'b0 : ~tape_reg;
        end else if (tx_state_reg != TX_IDLE) begin
            half_cnt_reg <= half_cnt_reg + ctc_pkg::CNT_W'(1);
        end
    end

    assign tx_busy       = busy_reg;
    assign tx_byte_ready = ready_reg;
    assign tape_out_flag = tape_reg;

    // ------------------------------------------------------------
    // tone decoder
    // ------------------------------------------------------------
    ctc_pkg::ctc_bit_s             rx_bit;
    ctc_rx_state_e                 rx_state_reg;
    logic [ctc_pkg::RX_BITS-1:0]   rx_shift_reg;
    logic [3:0]                    rx_cnt_reg;
    logic                          push_reg;
    logic                          ovr_reg;
    logic                          buf_full;
    ctc_pkg::ctc_rx_word_s         push_word_reg;

    ctc_cycle_meter #(
        .THRESH (THRESH),
        .GAP    (GAP)
    ) u_meter (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .tape_in (second_external_flag_input),
        .bit_out (rx_bit)
    );

    wire                          rx_last  = rx_bit.valid && rx_state_reg == RX_DATA && rx_cnt_reg == RB - 4'h1;
    wire [ctc_pkg::RX_BITS-1:0]   rx_full  = {rx_bit.one, rx_shift_reg[ctc_pkg::RX_BITS-1:1]};

    // bits arrive least significant first, so they shift in from the top
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rx_state_reg <= RX_HUNT;
            rx_shift_reg <= '0;
            rx_cnt_reg   <= '0;
        end else if (rx_bit.valid) begin
            case (rx_state_reg)
                RX_HUNT: begin
                    if (rx_bit.one) begin
                        rx_state_reg <= RX_DATA;
                        rx_cnt_reg   <= '0;
                    end
                end
                RX_DATA: begin
                    rx_shift_reg <= rx_full;
                    rx_cnt_reg   <= rx_cnt_reg + 4'h1;
                    if (rx_last) begin
                        rx_state_reg <= RX_HUNT;
                    end
                end
                default: rx_state_reg <= RX_HUNT;
            endcase
        end
    end

    // a third word arriving while both entries wait is dropped and flagged
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            push_reg      <= 1'b0;
            push_word_reg <= '0;
            ovr_reg       <= 1'b0;
        end else begin
            push_reg <= rx_last;
            ovr_reg  <= push_reg & buf_full;
            if (rx_last) begin
                push_word_reg.data      <= rx_full[ctc_pkg::DATA_BITS-1:0];
                push_word_reg.parity_ok <= ^rx_full;
            end
        end
    end

    ctc_pair_buffer #(
        .W ($bits(ctc_pkg::ctc_rx_word_s))
    ) u_rx_buf (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_valid  (push_reg),
        .in_data   (push_word_reg),
        .full      (buf_full),
        .out_valid (rx_valid),
        .out_data  (rx_word),
        .out_ready (rx_ready)
    );

    assign rx_overrun = ovr_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic                      tape_d_reg;
    logic [ctc_pkg::CNT_W-1:0] hold_cnt_reg;

    // counts how long the tape flag has stood at its level; idle time never counts
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tape_d_reg   <= 1'b0;
            hold_cnt_reg <= '0;
        end else begin
            tape_d_reg <= tape_reg;
            if (!busy_reg) begin
                hold_cnt_reg <= '0;
            end else if (tape_reg != tape_d_reg) begin
                hold_cnt_reg <= ctc_pkg::CNT_W'(1);
            end else begin
                hold_cnt_reg <= hold_cnt_reg + ctc_pkg::CNT_W'(1);
            end
        end
    end

    a_zero_half_len : assert property (@(posedge sys_clk) disable iff (!resetn)
        (half_done && !shift_reg[0]) |-> (hold_cnt_reg == ZH - ctc_pkg::CNT_W'(1)))
        else $error("zero half period wrong length");
    a_one_half_len : assert property (@(posedge sys_clk) disable iff (!resetn)
        (half_done && shift_reg[0]) |=> (tape_reg != $past(tape_reg) || $past(last_done)) && $past(half_cnt_reg) == OH - ctc_pkg::CNT_W'(1))
        else $error("one half period wrong length");
    a_leader_zeros : assert property (@(posedge sys_clk) disable iff (!resetn)
        (tx_state_reg == TX_LEADER) |-> (!shift_reg[0] && (tx_state_next == TX_LEADER || leader_ok)))
        else $error("leader broken before its time");
    a_byte_count : assert property (@(posedge sys_clk) disable iff (!resetn)
        (load) |=> (bytes_left_reg == $past(bytes_left_reg) - ctc_pkg::COUNT_W'(1) && tx_state_reg == TX_FRAME))
        else $error("byte count not kept");
    a_frame_start : assert property (@(posedge sys_clk) disable iff (!resetn)
        load |=> (shift_reg[0] == ctc_pkg::START_BIT && bits_left_reg == FB))
        else $error("frame missing start bit");
    a_frame_order : assert property (@(posedge sys_clk) disable iff (!resetn)
        load |=> (shift_reg[ctc_pkg::DATA_BITS:1] == $past(hold_reg)))
        else $error("payload bits out of order");
    a_odd_parity : assert property (@(posedge sys_clk) disable iff (!resetn)
        load |=> (^shift_reg[ctc_pkg::FRAME_BITS-1:1] == 1'b1))
        else $error("frame parity not odd");
    a_tape_moves : assert property (@(posedge sys_clk) disable iff (!resetn)
        (tape_reg != $past(tape_reg)) |-> ($past(half_done) || $past(start_ok)))
        else $error("tape flag toggled off a half boundary");
    a_tape_hold : assert property (@(posedge sys_clk) disable iff (!resetn)
        (busy_reg && !half_done) |-> (hold_cnt_reg <= OH))
        else $error("tape flag held too long");
    a_rx_parity : assert property (@(posedge sys_clk) disable iff (!resetn)
        rx_last |=> (push_reg && push_word_reg.parity_ok == ^$past(rx_full)))
        else $error("receive parity check wrong");

    c_leader_done : cover property (@(posedge sys_clk) disable iff (!resetn)
        tx_state_reg == TX_LEADER && load);
    c_tx_finish : cover property (@(posedge sys_clk) disable iff (!resetn) last_done);
    c_rx_word : cover property (@(posedge sys_clk) disable iff (!resetn) push_reg && !buf_full);
    c_rx_bad_par : cover property (@(posedge sys_clk) disable iff (!resetn) push_reg && !push_word_reg.parity_ok);
    c_rx_overrun : cover property (@(posedge sys_clk) disable iff (!resetn) ovr_reg);

endmodule : ctc_codec

// file: verification/ctc_tape_model.sv
// recorder model: records tone cycles from the codec and plays tone cycles back
module ctc_tape_model #(
    parameter int unsigned ZH = 5,
    parameter int unsigned OH = 12
) (
    // clock
    input  wire logic sys_clk,
    // recording head and playback output
    input  wire logic tape_rec,
    output logic      tape_play
);
    timeunit 1ns;
    timeprecision 1ns;
    int hi_cnt = 0;
    int widths[$];

    initial tape_play = 1'h0;

    // high half of each recorded cycle, in clocks
    always @(posedge sys_clk) begin
        if (tape_rec === 1'h1) begin
            hi_cnt++;
        end else if (hi_cnt != 0) begin
            widths.push_back(hi_cnt);
            hi_cnt = 0;
        end
    end

    // one full tone cycle: high half then low half
    task play_cycle(input logic one);
        tape_play = 1'h1;
        repeat (one ? OH : ZH) @(posedge sys_clk);
        #1;
        tape_play = 1'h0;
        repeat (one ? OH : ZH) @(posedge sys_clk);
        #1;
    endtask : play_cycle

    task play_zeros(input int n);
        repeat (n) play_cycle(1'h0);
    endtask : play_zeros

    // a bad frame carries even parity on purpose
    task play_byte(input logic [7:0] b, input logic good);
        int k;
        play_cycle(1'h1);
        for (k = 0; k < 8; k++) begin
            play_cycle(b[k]);
        end
        play_cycle(good ? ~^b : ^b);
    endtask : play_byte
endmodule : ctc_tape_model

// file: verification/cassette_tape_byte_codec_bench.sv
// testbench: cassette tape byte codec against the recorder model
module cassette_tape_byte_codec_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned ZH = 5;
    localparam int unsigned OH = 12;
    localparam int unsigned LEAD = 100;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic tx_start = 1'h0;
    logic [15:0] tx_count = 16'h0000;
    logic tx_busy;
    logic tx_byte_valid = 1'h0;
    logic [7:0] tx_byte = 8'h00;
    logic tx_byte_ready;
    logic tape_out_flag;
    logic tape_in;
    logic rx_valid;
    ctc_pkg::ctc_rx_word_s rx_word;
    logic rx_ready = 1'h0;
    logic rx_overrun;
    int fail_count = 0;
    int n_tests = 0;
    int ovr_count = 0;

    ctc_codec #(.ZERO_HALF(ZH), .ONE_HALF(OH), .THRESH(17), .GAP(50), .LEADER(LEAD)) uut (
        .sys_clk(sys_clk), .resetn(resetn), .tx_start(tx_start), .tx_count(tx_count),
        .tx_busy(tx_busy), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
        .tx_byte_ready(tx_byte_ready), .tape_out_flag(tape_out_flag),
        .second_external_flag_input(tape_in), .rx_valid(rx_valid), .rx_word(rx_word),
        .rx_ready(rx_ready), .rx_overrun(rx_overrun));
    ctc_tape_model #(.ZH(ZH), .OH(OH)) tape (.sys_clk(sys_clk), .tape_rec(tape_out_flag), .tape_play(tape_in));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (rx_overrun === 1'h1) ovr_count <= ovr_count + 1;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task fail(input string msg);
        $display("Error at %0t: %s", $time, msg);
        fail_count++;
    endtask : fail

    task final_report;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task step;
        @(posedge sys_clk);
        #1;
    endtask : step

    // valid stays up until ready was seen at a sampling edge
    task send_byte(input logic [7:0] b);
        int i;
        tx_byte = b;
        tx_byte_valid = 1'h1;
        for (i = 0; i < 3000 && tx_byte_ready !== 1'h1; i++) step;
        if (i == 3000) begin fail("byte never taken"); final_report; end
        step;
        tx_byte_valid = 1'h0;
    endtask : send_byte

    task next_bit(output logic v);
        int w;
        v = 1'h1;
        n_tests++;
        if (tape.widths.size() == 0) fail("missing tone cycle");
        else begin
            w = tape.widths.pop_front();
            v = (w == OH);
            if (w != ZH && w != OH) fail("tone half period off");
        end
    endtask : next_bit

    // stall zeros between frames are skipped; the leader is counted
    task check_frame(input logic [7:0] b, input logic lead);
        logic v;
        int z;
        int k;
        z = 0;
        next_bit(v);
        while (v === 1'h0) begin
            z++;
            next_bit(v);
        end
        n_tests++;
        if (lead && z < int'(LEAD / (2 * ZH))) fail("leader too short");
        for (k = 0; k < 8; k++) begin
            next_bit(v);
            n_tests++;
            if (v !== b[k]) fail("data bit wrong");
        end
        next_bit(v);
        n_tests++;
        if (v !== ~^b) fail("parity bit wrong");
    endtask : check_frame

    task take_word(input logic [7:0] d, input logic pok);
        int i;
        for (i = 0; i < 100 && rx_valid !== 1'h1; i++) step;
        if (i == 100) begin fail("no word received"); final_report; end
        n_tests++;
        if (rx_word.data !== d || rx_word.parity_ok !== pok) fail("received word wrong");
        rx_ready = 1'h1;
        step;
        rx_ready = 1'h0;
    endtask : take_word

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_refuse;
        tx_start = 1'h1;
        step;
        tx_start = 1'h0;
        step;
        n_tests++;
        if (tx_busy !== 1'h0 || tape_out_flag !== 1'h0) fail("zero count started a transfer");
    endtask : t_refuse

    // second byte comes late, so the codec must pad with zeros
    task t_tx;
        int i;
        send_byte(8'h96);
        tx_count = 16'h0002;
        tx_start = 1'h1;
        step;
        tx_start = 1'h0;
        n_tests++;
        if (tx_busy !== 1'h1 || tape_out_flag !== 1'h1) fail("tone did not start");
        repeat (400) step;
        send_byte(8'h81);
        for (i = 0; i < 5000 && tx_busy !== 1'h0; i++) step;
        if (i == 5000) begin fail("transfer never ended"); final_report; end
        check_frame(8'h96, 1'h1);
        check_frame(8'h81, 1'h0);
        n_tests++;
        if (tape.widths.size() != 0 || tape_out_flag !== 1'h0) fail("extra tone after last frame");
    endtask : t_tx

    // consumer stalls: two words fill the buffer, the third is dropped
    task t_rx;
        tape.play_zeros(4);
        tape.play_byte(8'hA5, 1'h1);
        tape.play_byte(8'h3C, 1'h0);
        tape.play_byte(8'h01, 1'h1);
        tape.play_zeros(2);
        repeat (10) step;
        n_tests++;
        if (ovr_count != 1) fail("overrun not flagged once");
        take_word(8'hA5, 1'h1);
        take_word(8'h3C, 1'h0);
        step;
        n_tests++;
        if (rx_valid !== 1'h0) fail("buffer not empty after drain");
    endtask : t_rx

    initial begin
        repeat (10) @(posedge sys_clk);
        #1;
        resetn = 1'h1;
        t_refuse;
        t_tx;
        t_rx;
        final_report;
    end
endmodule : cassette_tape_byte_codec_bench
